// >>> tb_uart_soft_flow_ctrl_config.sv
/*
 * Self-checking bench for the enhanced-feature control block.
 * Assumes the remote device model drives the receive side.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check(8'(g), 8'(e))
module tb_uart_soft_flow_ctrl_config;
    import ufc_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic       clk_i, rst_i, efc_we_i, char_we_i, ext_we_i, sleep_req_i;
    logic [7:0] efc_wdata_i, char_wdata_i, ext_wdata_i;
    logic [1:0] char_sel_i;
    logic [2:0] ext_sel_i;
    wire logic       rx_valid_i;
    wire logic [7:0] rx_data_i;
    logic [7:0] efc_rdata_o, ier_ext_o, iir_ext_o, fcr_ext_o, mcr_ext_o;
    logic [7:0] tcr_o, tlr_o, rx_fifo_data_o, seen_d, d, oth;
    logic       sleep_o, rx_fifo_we_o, special_irq_o, pause_irq_o;
    logic       tx_pause_o, tx_send_one_o, tx_send_two_o;
    logic       seen_we, seen_sp, seen_pi, seen_clr;
    logic [7:0] ext_m [6];
    logic [7:0] fc [4];
    int         fails, tests_run, seed;

    ufc_flow_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .efc_we_i(efc_we_i),
        .efc_wdata_i(efc_wdata_i), .char_we_i(char_we_i),
        .char_sel_i(char_sel_i), .char_wdata_i(char_wdata_i),
        .ext_we_i(ext_we_i), .ext_sel_i(ext_sel_i),
        .ext_wdata_i(ext_wdata_i), .sleep_req_i(sleep_req_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .efc_rdata_o(efc_rdata_o), .ier_ext_o(ier_ext_o),
        .iir_ext_o(iir_ext_o), .fcr_ext_o(fcr_ext_o),
        .mcr_ext_o(mcr_ext_o), .tcr_o(tcr_o), .tlr_o(tlr_o),
        .sleep_o(sleep_o), .rx_fifo_we_o(rx_fifo_we_o),
        .rx_fifo_data_o(rx_fifo_data_o), .special_irq_o(special_irq_o),
        .pause_irq_o(pause_irq_o), .tx_pause_o(tx_pause_o),
        .tx_send_one_o(tx_send_one_o), .tx_send_two_o(tx_send_two_o));
    ufc_remote_dev REM (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i));

    // ************************************************************
    // Helpers
    // ************************************************************
    // Pulses are collected so the check does not hinge on exact latency
    // Only this process writes the seen flags; the bench asks via seen_clr
    always @(posedge clk_i) begin
        if (seen_clr) begin
            seen_we <= 1'b0;
            seen_sp <= 1'b0;
            seen_pi <= 1'b0;
        end else begin
            if (rx_fifo_we_o === 1'b1) begin
                seen_we <= 1'b1;
                seen_d  <= rx_fifo_data_o;
            end
            if (special_irq_o === 1'b1) seen_sp <= 1'b1;
            if (pause_irq_o === 1'b1) seen_pi <= 1'b1;
        end
    end

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask

    function automatic logic [7:0] msk(input int s);
        case (s)
            0: return IER_PROT_MASK;
            1: return IIR_PROT_MASK;
            2: return FCR_PROT_MASK;
            3: return MCR_PROT_MASK;
            default: return 8'hFF;
        endcase
    endfunction

    function automatic logic [7:0] ext_out(input int s);
        case (s)
            0: return ier_ext_o;
            1: return iir_ext_o;
            2: return fcr_ext_o;
            3: return mcr_ext_o;
            4: return tcr_o;
            default: return tlr_o;
        endcase
    endfunction

    task automatic wr(input int k, input int s, input logic [7:0] v);
        @(posedge clk_i);
        #1;
        efc_we_i     = (k == 0);
        char_we_i    = (k == 1);
        ext_we_i     = (k == 2);
        efc_wdata_i  = v;
        char_wdata_i = v;
        ext_wdata_i  = v;
        char_sel_i   = 2'(s);
        ext_sel_i    = 3'(s);
        @(posedge clk_i);
        #1;
        efc_we_i  = 1'b0;
        char_we_i = 1'b0;
        ext_we_i  = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic efc(input logic [7:0] v);
        wr(0, 0, v);
        `CHK(efc_rdata_o, v);
        `CHK({tx_send_one_o, tx_send_two_o}, v[3:2]);
    endtask

    // Expect order {fifo write, special, pause irq, paused}
    task automatic rx(input logic [7:0] a, input logic [7:0] b, input bit pr,
                      input logic [3:0] e, input logic [3:0] c);
        seen_clr = 1'b1;
        @(posedge clk_i);
        #1;
        seen_clr = 1'b0;
        if (pr) REM.send_pair(a, b);
        else REM.send(a, 0);
        repeat (3) @(posedge clk_i);
        #1;
        `CHK({seen_we, seen_sp, seen_pi, tx_pause_o} & c, e & c);
        if (e[3] & c[3]) `CHK(seen_d, a);
    endtask

    task automatic summarize();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog, sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        #100000;
        fails++;
        summarize();
    end

    initial begin
        {rst_i, efc_we_i, char_we_i, ext_we_i, sleep_req_i} = 5'h10;
        {efc_wdata_i, char_wdata_i, ext_wdata_i} = 24'h000000;
        {char_sel_i, ext_sel_i} = 5'h00;
        seen_clr = 1'b1;
        fails = 0;
        tests_run = 0;
        seed = 32'h6E99C8C6;
        repeat (20) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(efc_rdata_o, EFC_RESET);
        for (int j = 0; j < 6; j++) ext_m[j] = EXT_RESET;
        for (int p = 0; p < 2; p++) begin
            efc(p ? 8'h10 : 8'h00);
            for (int s = 0; s < 7; s++) begin
                d = 8'($random(seed));
                wr(2, s, d);
                if (s < 6) ext_m[s] = p ? d : (ext_m[s] & msk(s)) |
                                              (d & ~msk(s));
                for (int j = 0; j < 6; j++) begin
                    `CHK(ext_out(j), ext_m[j]);
                end
            end
        end
        sleep_req_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(sleep_o, 1'b1);
        efc(8'h00);
        `CHK(sleep_o, 1'b0);
        sleep_req_i = 1'b0;
        repeat (6) efc(8'($random(seed)) & 8'h3F);
        d = 8'($random(seed));
        for (int i = 0; i < 4; i++) begin
            fc[i] = d + 8'(i);
            wr(1, i, fc[i]);
        end
        oth = d + 8'h10;
        efc(8'h00);
        rx(fc[3], 8'h00, 0, 4'b1000, 4'hF);
        efc(8'h20);
        rx(fc[3], 8'h00, 0, 4'b1100, 4'hF);
        efc(8'h21);
        rx(fc[3], 8'h00, 0, 4'b0111, 4'hF);
        rx(fc[1], 8'h00, 0, 4'b0000, 4'hF);
        rx(fc[2], 8'h00, 0, 4'b1000, 4'hF);
        efc(8'h02);
        rx(fc[3], 8'h00, 0, 4'b1000, 4'hF);
        rx(fc[2], 8'h00, 0, 4'b0011, 4'hF);
        rx(fc[0], 8'h00, 0, 4'b0000, 4'hF);
        efc(8'h0B);
        rx(fc[3], 8'h00, 0, 4'b0011, 4'hF);
        rx(fc[0], 8'h00, 0, 4'b0000, 4'hF);
        efc(8'h07);
        rx(fc[2], 8'h00, 0, 4'b0011, 4'hF);
        rx(fc[1], 8'h00, 0, 4'b0000, 4'hF);
        efc(8'h03);
        rx(fc[2], 8'h00, 0, 4'b0000, 4'b0001);
        rx(oth, 8'h00, 0, 4'b1000, 4'b1001);
        rx(fc[3], 8'h00, 0, 4'b0000, 4'b0001);
        rx(fc[3], fc[2], 1, 4'b0000, 4'b0001);
        rx(fc[2], fc[3], 1, 4'b0001, 4'b0001);
        rx(fc[0], fc[1], 1, 4'b0000, 4'b0001);
        efc(8'h0F);
        rx(fc[2], fc[3], 1, 4'b0011, 4'b0011);
        summarize();
    end
endmodule // tb_uart_soft_flow_ctrl_config
`default_nettype wire

// >>> ufc_char_cmp.sv
/*
 * Compares a received byte with the four flow characters in one generate
 * loop. hit[0..3] = resume one, resume two, pause one, pause two.
 * Assumes stable inputs during the cycle that reads hit.
 */
`timescale 1ns/10ps
`default_nettype none
module ufc_char_cmp
    import ufc_pkg::*;
(
    ufc_match_if.cmp m
);
    logic [7:0] chars [4];
    assign chars[0] = m.resume_char_one;
    assign chars[1] = m.resume_char_two;
    assign chars[2] = m.pause_char_one;
    assign chars[3] = m.pause_char_two;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cmp
            assign m.hit[g] = (m.rx_data == chars[g]);
        end
    endgenerate
endmodule // ufc_char_cmp
`default_nettype wire

// >>> ufc_flow_ctrl.sv
/*
 * Enhanced-feature control of a UART: software flow control select,
 * special character detection, enhanced-function write gating.
 * Assumes the UART core presents one received character in each cycle that
 * rx_valid_i is high and sends the flow characters that tx_* outputs ask for.
 */
//
// Summary of operation
// RL1: Bit 5 set enables special-character matching.
// RL2: Second pause char stored, flag special interrupt.
// RL3: Compared second pause still pauses transmitter.
// RL4: Then not stored; pause and special interrupts.
// RL5: Bit 4 gates writes to extended fields.
// RL6: Bit 4 required for sleep mode.
// RL7: Bits 3:2 choose transmitted flow characters.
// RL8: Bits 1:0 choose received comparison characters.
// RL9: Codes 1011/0111: receiver accepts either character.
// RL10: Code 1111: send both, match both.
// RL11: Code 0011: no transmit, receiver matches pairs.
// RL12: Pair characters must arrive consecutively.
`timescale 1ns/10ps
`default_nettype none
module ufc_flow_ctrl
    import ufc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       efc_we_i,
    input  wire logic [7:0] efc_wdata_i,
    input  wire logic       char_we_i,
    input  wire logic [1:0] char_sel_i,
    input  wire logic [7:0] char_wdata_i,
    input  wire logic       ext_we_i,
    input  wire logic [2:0] ext_sel_i,
    input  wire logic [7:0] ext_wdata_i,
    input  wire logic       sleep_req_i,
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_data_i,
    output logic [7:0]      efc_rdata_o,
    output logic [7:0]      ier_ext_o,
    output logic [7:0]      iir_ext_o,
    output logic [7:0]      fcr_ext_o,
    output logic [7:0]      mcr_ext_o,
    output logic [7:0]      tcr_o,
    output logic [7:0]      tlr_o,
    output logic            sleep_o,
    output logic            rx_fifo_we_o,
    output logic [7:0]      rx_fifo_data_o,
    output logic            special_irq_o,
    output logic            pause_irq_o,
    output logic            tx_pause_o,
    output logic            tx_send_one_o,
    output logic            tx_send_two_o
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] efc_reg;
    logic [7:0] chars_reg [4];
    logic [7:0] ier_reg, iir_reg, fcr_reg, mcr_reg, tcr_reg, tlr_reg;
    ufc_pair_e  pair_reg;
    logic       pause_reg;

    ufc_match_if m ();
    assign m.resume_char_one = chars_reg[0];
    assign m.resume_char_two = chars_reg[1];
    assign m.pause_char_one  = chars_reg[2];
    assign m.pause_char_two  = chars_reg[3];
    assign m.rx_data         = rx_data_i;
    ufc_char_cmp u_cmp (.m(m));

    wire logic       special_en = efc_reg[EFC_SPECIAL_BIT];
    wire logic       enhance_en = efc_reg[EFC_ENHANCE_BIT];
    wire logic [1:0] tx_sel = efc_reg[EFC_TXSEL_HI:EFC_TXSEL_LO];
    wire logic [1:0] rx_sel = efc_reg[EFC_RXSEL_HI:EFC_RXSEL_LO];
    wire logic [3:0] code   = efc_reg[EFC_TXSEL_HI:EFC_RXSEL_LO];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            efc_reg <= EFC_RESET;
        end else if (efc_we_i) begin
            efc_reg <= efc_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) chars_reg[i] <= CHAR_RESET;
        end else if (char_we_i) begin
            chars_reg[char_sel_i] <= char_wdata_i;
        end
    end

    // ************************************************************
    // Enhanced field write gating
    // ************************************************************
    // Protected bits keep their value unless the enhance bit is set
    function automatic logic [7:0] gated(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask,
                                         input logic       en);
        gated = en ? new_v : ((new_v & ~mask) | (old_v & mask));
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ier_reg <= EXT_RESET;
            iir_reg <= EXT_RESET;
            fcr_reg <= EXT_RESET;
            mcr_reg <= EXT_RESET;
            tcr_reg <= EXT_RESET;
            tlr_reg <= EXT_RESET;
        end else if (ext_we_i) begin
            case (ext_sel_i)
                3'h0: ier_reg <= gated(ier_reg, ext_wdata_i,
                                       IER_PROT_MASK, enhance_en); // [RL5]
                3'h1: iir_reg <= gated(iir_reg, ext_wdata_i,
                                       IIR_PROT_MASK, enhance_en); // [RL5]
                3'h2: fcr_reg <= gated(fcr_reg, ext_wdata_i,
                                       FCR_PROT_MASK, enhance_en); // [RL5]
                3'h3: mcr_reg <= gated(mcr_reg, ext_wdata_i,
                                       MCR_PROT_MASK, enhance_en); // [RL5]
                3'h4: if (enhance_en) tcr_reg <= ext_wdata_i;      // [RL5]
                3'h5: if (enhance_en) tlr_reg <= ext_wdata_i;      // [RL5]
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) sleep_o <= 1'b0;
        else sleep_o <= sleep_req_i & enhance_en; // [RL6]
    end

    // ************************************************************
    // Receive comparison
    // ************************************************************
    logic any_resume, any_pause, pair_mode, cmp_p2;
    always_comb begin
        any_resume = 1'b0;
        any_pause  = 1'b0;
        pair_mode  = (code == CODE_BOTH) ||
                     (code == CODE_RX_PAIR); // [RL10] [RL11]
        cmp_p2     = 1'b0;
        case (rx_sel)                                               // [RL8]
            RX_ONE: begin
                any_resume = m.hit[0];
                any_pause  = m.hit[2];
            end
            RX_TWO: begin
                any_resume = m.hit[1];
                any_pause  = m.hit[3];
                cmp_p2     = m.hit[3];
            end
            RX_EITHER_OR_PAIR: begin
                if (!pair_mode) begin                               // [RL9]
                    any_resume = m.hit[0] | m.hit[1];
                    any_pause  = m.hit[2] | m.hit[3];
                    cmp_p2     = m.hit[3];
                end
            end
            default: ;
        endcase
    end

    // Pair tracking: second character must follow the first directly
    logic pair_resume, pair_pause, pair_p2;
    always_comb begin
        pair_resume = pair_mode && rx_sel == RX_EITHER_OR_PAIR &&
                      pair_reg == UFC_PAIR_RESUME && m.hit[1]; // [RL12]
        pair_pause  = pair_mode && rx_sel == RX_EITHER_OR_PAIR &&
                      pair_reg == UFC_PAIR_PAUSE && m.hit[3];  // [RL12]
        pair_p2     = pair_pause;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_reg <= UFC_PAIR_IDLE;
        end else if (rx_valid_i) begin
            if (pair_mode && m.hit[0]) pair_reg <= UFC_PAIR_RESUME;
            else if (pair_mode && m.hit[2]) pair_reg <= UFC_PAIR_PAUSE;
            else pair_reg <= UFC_PAIR_IDLE;
        end
    end

    wire logic do_resume = any_resume | pair_resume;
    wire logic do_pause  = any_pause | pair_pause;
    wire logic flow_p2   = cmp_p2 | pair_p2;
    wire logic flow_char = do_resume | do_pause |
                           (pair_mode && (m.hit[0] || m.hit[2]));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pause_reg <= 1'b0;
        end else if (rx_valid_i && rx_sel != RX_NONE) begin
            if (do_pause) pause_reg <= 1'b1;   // [RL3]
            else if (do_resume) pause_reg <= 1'b0;
        end
    end
    assign tx_pause_o = pause_reg;

    // ************************************************************
    // Receive FIFO feed and interrupt events
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_fifo_we_o   <= 1'b0;
            rx_fifo_data_o <= 8'h00;
            special_irq_o  <= 1'b0;
            pause_irq_o    <= 1'b0;
        end else begin
            rx_fifo_data_o <= rx_data_i;
            // Flow characters are consumed; special char stays otherwise
            rx_fifo_we_o  <= rx_valid_i &
                             !(rx_sel != RX_NONE && flow_char); // [RL2] [RL4]
            special_irq_o <= rx_valid_i & special_en & m.hit[3] &
                             (rx_sel == RX_NONE || !flow_char ||
                              flow_p2); // [RL1] [RL4]
            pause_irq_o   <= rx_valid_i & (rx_sel != RX_NONE) &
                             do_pause;                             // [RL4]
        end
    end

    // ************************************************************
    // Transmit select and register readback
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_send_one_o <= 1'b0;
            tx_send_two_o <= 1'b0;
        end else begin
            tx_send_one_o <= tx_sel[1];                            // [RL7]
            tx_send_two_o <= tx_sel[0];                            // [RL7]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            efc_rdata_o <= EFC_RESET;
            ier_ext_o <= EXT_RESET;
            iir_ext_o <= EXT_RESET;
            fcr_ext_o <= EXT_RESET;
            mcr_ext_o <= EXT_RESET;
            tcr_o <= EXT_RESET;
            tlr_o <= EXT_RESET;
        end else begin
            efc_rdata_o <= efc_reg;
            ier_ext_o <= ier_reg;
            iir_ext_o <= iir_reg;
            fcr_ext_o <= fcr_reg;
            mcr_ext_o <= mcr_reg;
            tcr_o <= tcr_reg;
            tlr_o <= tlr_reg;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_special_off: assert property (!special_en |=> !special_irq_o) // [RL1]
        else $error("special irq with detection off");
    chk_special_store: assert property ( // [RL2]
        rx_valid_i && special_en && m.hit[3] && rx_sel == RX_NONE
        |=> special_irq_o && rx_fifo_we_o)
        else $error("special char not stored and flagged");
    chk_pause_acts: assert property ( // [RL3]
        rx_valid_i && rx_sel == RX_TWO && m.hit[3] |=> tx_pause_o)
        else $error("pause char did not pause");
    chk_combined_drop: assert property ( // [RL4]
        rx_valid_i && special_en && rx_sel == RX_TWO && m.hit[3]
        |=> !rx_fifo_we_o && pause_irq_o && special_irq_o)
        else $error("combined pause case wrong");
    chk_tcr_locked: assert property ( // [RL5]
        ext_we_i && ext_sel_i == 3'h4 && !enhance_en
        |=> tcr_reg == $past(tcr_reg))
        else $error("tcr changed while locked");
    chk_sleep_gate: assert property (!enhance_en |=> !sleep_o) // [RL6]
        else $error("sleep while enhance off");
    chk_tx_select: assert property ( // [RL7]
        1'b1 |=> tx_send_one_o == $past(tx_sel[1]) &&
                 tx_send_two_o == $past(tx_sel[0]))
        else $error("tx select mismatch");
    chk_rx_none: assert property ( // [RL8]
        rx_valid_i && rx_sel == RX_NONE |=> rx_fifo_we_o && !pause_irq_o)
        else $error("rx none compared");
    chk_single_any: assert property ( // [RL9]
        rx_valid_i && code == CODE_ONE_ANY && m.hit[3] |=> tx_pause_o)
        else $error("either pause not accepted");
    chk_pair_lone: assert property ( // [RL10] [RL11] [RL12]
        rx_valid_i && pair_mode && pair_reg == UFC_PAIR_IDLE && m.hit[3]
        && !m.hit[2] && !m.hit[0] && !tx_pause_o |=> !tx_pause_o)
        else $error("lone second pause accepted in pair mode");
    cov_pause: cover property (@(posedge clk_i) pause_irq_o);
    cov_special: cover property (@(posedge clk_i) special_irq_o && rx_fifo_we_o);
    cov_pair: cover property (@(posedge clk_i) pair_pause && rx_valid_i);
endmodule // ufc_flow_ctrl
`default_nettype wire

// >>> ufc_match_if.sv
/*
 * Carrier between the top module and the character matcher: the four flow
 * characters, the received byte and the match results.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface ufc_match_if;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic [7:0] rx_data;
    logic [3:0] hit;
    modport top (output resume_char_one, resume_char_two, pause_char_one,
                 pause_char_two, rx_data, input hit);
    modport cmp (input resume_char_one, resume_char_two, pause_char_one,
                 pause_char_two, rx_data, output hit);
endinterface
`default_nettype wire

// >>> ufc_pkg.sv
/*
 * Package for the enhanced-feature control block: field positions of the
 * enhanced feature control register, flow control codes, reset values.
 * Assumes nothing of its surroundings.
 */
package ufc_pkg;
    // ************************************************************
    // Enhanced feature control register fields
    // ************************************************************
    localparam int unsigned EFC_SPECIAL_BIT = 5;
    localparam int unsigned EFC_ENHANCE_BIT = 4;
    localparam int unsigned EFC_TXSEL_HI    = 3;
    localparam int unsigned EFC_TXSEL_LO    = 2;
    localparam int unsigned EFC_RXSEL_HI    = 1;
    localparam int unsigned EFC_RXSEL_LO    = 0;
    localparam logic [7:0]  EFC_RESET       = 8'h00;
    localparam logic [7:0]  CHAR_RESET      = 8'h00;
    localparam logic [7:0]  EXT_RESET       = 8'h00;

    // ************************************************************
    // Flow control select codes
    // ************************************************************
    localparam logic [1:0] TX_NONE  = 2'h0;
    localparam logic [1:0] TX_ONE   = 2'h2;
    localparam logic [1:0] TX_TWO   = 2'h1;
    localparam logic [1:0] TX_BOTH  = 2'h3;
    localparam logic [1:0] RX_NONE  = 2'h0;
    localparam logic [1:0] RX_ONE   = 2'h2;
    localparam logic [1:0] RX_TWO   = 2'h1;
    localparam logic [1:0] RX_EITHER_OR_PAIR = 2'h3;
    localparam logic [3:0] CODE_ONE_ANY  = 4'hB;
    localparam logic [3:0] CODE_TWO_ANY  = 4'h7;
    localparam logic [3:0] CODE_BOTH     = 4'hF;
    localparam logic [3:0] CODE_RX_PAIR  = 4'h3;

    // Protected field masks for writes gated by the enhance bit
    localparam logic [7:0] IER_PROT_MASK = 8'hF0;
    localparam logic [7:0] IIR_PROT_MASK = 8'h30;
    localparam logic [7:0] FCR_PROT_MASK = 8'h30;
    localparam logic [7:0] MCR_PROT_MASK = 8'hE0;

    typedef enum logic [1:0] {
        UFC_PAIR_IDLE   = 2'b00,
        UFC_PAIR_RESUME = 2'b01,
        UFC_PAIR_PAUSE  = 2'b10
    } ufc_pair_e;
endpackage

// >>> ufc_remote_dev.sv
/*
 * Model of the remote serial device: hands received characters to the
 * block one at a time, or as a back-to-back pair.
 * Assumes the bench calls its tasks from a single process.
 */
`timescale 1ns/10ps
`default_nettype none
module ufc_remote_dev (
    input  wire logic       clk_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);
    // ************************************************************
    // Character sender
    // ************************************************************
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
    end

    // Idle data is the inverse of the last byte, so stale data never matches
    task automatic send(input logic [7:0] c, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_data_o  = c;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_data_o  = ~c;
    endtask

    // Valid stays up across both characters of a pair
    task automatic send_pair(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_data_o  = a;
        @(posedge clk_i);
        #1;
        rx_data_o  = b;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_data_o  = ~b;
    endtask
endmodule // ufc_remote_dev
`default_nettype wire
